// ---- design/tcs_pkg.sv ----
// constants for the transmit collision statistics block
package tcs_pkg;

	// management addressing
	localparam logic [4:0] STAT_DEV = 5'h01;
	localparam logic [9:0] STAT_PAGE = 10'h30a;
	localparam logic [9:0] CTRL_PAGE = 10'h301;
	localparam logic [4:0] THR_REG = 5'h15;

	// counter bank
	localparam int NUM_CNT = 7;
	localparam int CNT_SINGLE = 0;
	localparam int CNT_EXCESS = 1;
	localparam int CNT_MULTI = 2;
	localparam int CNT_LATE = 3;
	localparam int CNT_TOTAL = 4;
	localparam int CNT_DEFER = 5;
	localparam int CNT_NOCRS = 6;
	localparam logic [31:0] CNT_RST = 32'h0000_0000;

	// upper half register of each pair; lower half sits one above
	localparam logic [4:0] REG_SINGLE = 5'h10;
	localparam logic [4:0] REG_EXCESS = 5'h12;
	localparam logic [4:0] REG_MULTI = 5'h14;
	localparam logic [4:0] REG_LATE = 5'h17;
	localparam logic [4:0] REG_TOTAL = 5'h19;
	localparam logic [4:0] REG_DEFER = 5'h1b;
	localparam logic [4:0] REG_NOCRS = 5'h1d;
	localparam logic [6:0][4:0] CNT_REG = {REG_NOCRS, REG_DEFER, REG_TOTAL,
		REG_LATE, REG_MULTI, REG_EXCESS, REG_SINGLE};

	// collision threshold register fields
	localparam int THR_POS = 1;
	localparam int THR_W = 8;
	localparam int RETRY_LATE_POS = 0;
	localparam logic [7:0] THR_RST = 8'h0f;
	localparam logic RETRY_LATE_RST = 1'b0;

	// per packet collision limit
	localparam logic [4:0] EXCESS_COLL = 5'h10;
	localparam logic [7:0] EXCESS_THR = 8'h10;

	// slot time, 512 bit times at 100 Mb/s
	localparam int SLOT_NS = 5120;
	localparam int CLK_NS = 10;
	localparam logic [9:0] SLOT_CYC = 10'((SLOT_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ---- design/tcs_counter.sv ----
// one 32-bit wrapping statistics counter
`timescale 1ns/1ps
module tcs_counter
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// event
	input wire logic inc,
	// value
	output logic [31:0] count
);

	// plain binary add wraps from all ones to zero
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			count <= tcs_pkg::CNT_RST;
		else if (ce && inc)
			count <= count + 32'h0000_0001;
	end

endmodule

// ---- design/tcs_stats.sv ----
// transmit collision statistics counters with management read port
//
// Operation
// - each counter shows as two 16-bit registers, upper half at lower number
// - counters at device 01 page 778 from register 16, 32-bit, RO, reset 0
// - single counter counts good packets with exactly one collision
// - collision counters move only when tx enabled and half duplex
// - excessive counter counts packets with 16 or more collisions
// - excessive counter never moves when retry threshold is below 16
// - multiple counter counts transmits with 2 to 15 collisions
// - late counter counts packets colliding after one slot time
// - total counter adds every collision seen by the transmitter
// - defer counter counts packets that cannot go at once
// - defer counter needs only tx enabled, any duplex mode
// - defer counter ignores streaming transmits held only by tx gap
// - no-carrier counter counts good sends lacking carrier within slot
// - transmission start is the cycle tx_en rises toward the phy
// - phy carrier sense is expected during every transmission
// - no-carrier counter moves only when tx enabled
// - retry threshold is 8-bit field at bits 8:1, reset 0x0f
`timescale 1ns/1ps
module tcs_stats
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// transmit mac status, same clock
	input wire logic tx_enable,
	input wire logic half_duplex,
	input wire logic tx_en,
	input wire logic pkt_done,
	input wire logic pkt_ok,
	input wire logic defer_evt,
	input wire logic defer_ipg_only,
	// phy pins
	input wire logic crs_pin,
	input wire logic col_pin,
	// management access
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [4:0] mgmt_dev,
	input wire logic [9:0] mgmt_page,
	input wire logic [4:0] mgmt_reg,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	// retry control toward the mac
	output logic [7:0] coll_threshold,
	output logic retry_late
);

	localparam int NUM_CNT_W = tcs_pkg::NUM_CNT;

	logic crs_s1_q;
	logic crs_s2_q;
	logic col_s1_q;
	logic col_s2_q;
	logic col_s3_q;
	logic tx_en_d1_q;
	logic tx_start;
	logic col_edge;
	logic gate_hd;
	logic gate_tx;
	logic [9:0] slot_cnt_q;
	logic slot_over;
	logic crs_seen_q;
	logic [4:0] col_n_q;
	logic late_q;
	logic [7:0] thr_q;
	logic retry_late_q;
	logic [NUM_CNT_W-1:0] inc;
	logic [31:0] cnt [tcs_pkg::NUM_CNT];
	logic stat_sel;
	logic ctrl_sel;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_q;
	logic snap_take;
	logic [2:0] snap_idx_d;
	logic [15:0] snap_q;
	logic [2:0] snap_idx_q;
	logic snap_vld_q;

	// phy pins cross in through two flops; third flop only finds edges
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			crs_s1_q <= 1'b0;
			crs_s2_q <= 1'b0;
			col_s1_q <= 1'b0;
			col_s2_q <= 1'b0;
			col_s3_q <= 1'b0;
			tx_en_d1_q <= 1'b0;
		end
		else if (ce)
		begin
			crs_s1_q <= crs_pin;
			crs_s2_q <= crs_s1_q;
			col_s1_q <= col_pin;
			col_s2_q <= col_s1_q;
			col_s3_q <= col_s2_q;
			tx_en_d1_q <= tx_en;
		end
	end

	assign tx_start = tx_en & ~tx_en_d1_q;
	assign col_edge = col_s2_q & ~col_s3_q & tx_en;
	assign gate_hd = tx_enable & half_duplex;
	assign gate_tx = tx_enable;

	// slot timer restarts on every attempt and parks at one slot time
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			slot_cnt_q <= 10'h000;
		else if (ce)
		begin
			if (tx_start)
				slot_cnt_q <= 10'h000;
			else if (tx_en && !slot_over)
				slot_cnt_q <= slot_cnt_q + 10'h001;
		end
	end

	assign slot_over = slot_cnt_q == tcs_pkg::SLOT_CYC;

	// carrier must show within the slot of each attempt
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			crs_seen_q <= 1'b0;
		else if (ce)
		begin
			if (tx_start)
				crs_seen_q <= crs_s2_q;
			else if (tx_en && !slot_over && crs_s2_q)
				crs_seen_q <= 1'b1;
		end
	end

	// per packet collision tally over all retries; saturates at sixteen
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			col_n_q <= 5'h00;
		else if (ce)
		begin
			if (pkt_done)
				col_n_q <= 5'h00;
			else if (col_edge && col_n_q != tcs_pkg::EXCESS_COLL)
				col_n_q <= col_n_q + 5'h01;
		end
	end

	// a collision past the slot marks the packet late
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			late_q <= 1'b0;
		else if (ce)
		begin
			if (pkt_done)
				late_q <= 1'b0;
			else if (col_edge && slot_over)
				late_q <= 1'b1;
		end
	end

	// counter events
	assign inc[tcs_pkg::CNT_SINGLE] = pkt_done & pkt_ok & gate_hd &
		(col_n_q == 5'h01);
	// threshold test keeps the counter still when retries stop early
	assign inc[tcs_pkg::CNT_EXCESS] = pkt_done & gate_hd &
		(col_n_q >= tcs_pkg::EXCESS_COLL) &
		(thr_q >= tcs_pkg::EXCESS_THR);
	assign inc[tcs_pkg::CNT_MULTI] = pkt_done & pkt_ok & gate_hd &
		(col_n_q > 5'h01) & (col_n_q < tcs_pkg::EXCESS_COLL);
	assign inc[tcs_pkg::CNT_LATE] = pkt_done & late_q & gate_hd;
	assign inc[tcs_pkg::CNT_TOTAL] = col_edge & gate_hd;
	assign inc[tcs_pkg::CNT_DEFER] = defer_evt & ~defer_ipg_only &
		gate_tx;
	assign inc[tcs_pkg::CNT_NOCRS] = pkt_done & pkt_ok & ~crs_seen_q &
		gate_tx;

	// counter bank; each wraps on its own
	for (genvar i = 0; i < tcs_pkg::NUM_CNT; i++)
	begin : g_cnt
		tcs_counter u_cnt
		(
			.mclk(mclk),
			.rst_b(rst_b),
			.ce(ce),
			.inc(inc[i]),
			.count(cnt[i])
		);
	end

	// retry threshold register, software written
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			thr_q <= tcs_pkg::THR_RST;
			retry_late_q <= tcs_pkg::RETRY_LATE_RST;
		end
		else if (ce && mgmt_wr && ctrl_sel)
		begin
			thr_q <= mgmt_wdata[tcs_pkg::THR_POS +:
				tcs_pkg::THR_W];
			retry_late_q <= mgmt_wdata[tcs_pkg::RETRY_LATE_POS];
		end
	end

	assign coll_threshold = thr_q;
	assign retry_late = retry_late_q;

	assign stat_sel = mgmt_dev == tcs_pkg::STAT_DEV &&
		mgmt_page == tcs_pkg::STAT_PAGE;
	assign ctrl_sel = mgmt_dev == tcs_pkg::STAT_DEV &&
		mgmt_page == tcs_pkg::CTRL_PAGE && mgmt_reg == tcs_pkg::THR_REG;

	// read mux; unmapped registers read zero, writes to counters ignored
	always_comb
	begin
		rdata_d = 16'h0000;
		snap_take = 1'b0;
		snap_idx_d = 3'h0;
		if (ctrl_sel)
		begin
			rdata_d[tcs_pkg::THR_POS +: tcs_pkg::THR_W] = thr_q;
			rdata_d[tcs_pkg::RETRY_LATE_POS] = retry_late_q;
		end
		for (int i = 0; i < tcs_pkg::NUM_CNT; i++)
		begin
			if (stat_sel && mgmt_reg == tcs_pkg::CNT_REG[i])
			begin
				rdata_d = cnt[i][31:16];
				snap_take = 1'b1;
				snap_idx_d = 3'(i);
			end
			if (stat_sel && mgmt_reg == tcs_pkg::CNT_REG[i] + 5'h01)
			begin
				if (snap_vld_q && snap_idx_q == 3'(i))
					rdata_d = snap_q;
				else
					rdata_d = cnt[i][15:0];
			end
		end
	end

	// reading the upper half freezes the lower half for the pair read
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			snap_q <= 16'h0000;
			snap_idx_q <= 3'h0;
			snap_vld_q <= 1'b0;
		end
		else if (ce && mgmt_rd)
		begin
			snap_vld_q <= snap_take;
			if (snap_take)
			begin
				snap_q <= cnt[snap_idx_d][15:0];
				snap_idx_q <= snap_idx_d;
			end
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end
		else if (ce)
		begin
			rvalid_q <= mgmt_rd;
			if (mgmt_rd)
				rdata_q <= rdata_d;
		end
	end

	assign mgmt_rdata = rdata_q;
	assign mgmt_rvalid = rvalid_q;

	// checks
	single_count_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && pkt_done && pkt_ok && gate_hd && col_n_q == 5'h01
		|=> cnt[0] == 32'($past(cnt[0]) + 32'h1))
		else $error("single collision count missed");

	duplex_hold_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		!half_duplex |=> $stable(cnt[4]) && $stable(cnt[2]))
		else $error("collision counter moved in full duplex");

	excess_block_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		thr_q < 8'h10 |=> $stable(cnt[1]))
		else $error("excess counter moved under low threshold");

	multi_range_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && pkt_done && gate_hd && col_n_q == 5'h10 &&
		thr_q >= 8'h10
		|=> $stable(cnt[2]) && cnt[1] == 32'($past(cnt[1]) + 32'h1))
		else $error("sixteen collisions counted wrongly");

	total_edge_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && gate_hd && tx_en && col_s2_q && !col_s3_q
		|=> cnt[4] == 32'($past(cnt[4]) + 32'h1))
		else $error("collision not added to total");

	defer_fd_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && tx_enable && !half_duplex && defer_evt && !defer_ipg_only
		|=> cnt[5] == 32'($past(cnt[5]) + 32'h1))
		else $error("defer not counted in full duplex");

	defer_ipg_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		defer_ipg_only |=> $stable(cnt[5]))
		else $error("gap only defer was counted");

	nocrs_count_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && pkt_done && pkt_ok && tx_enable && !crs_seen_q
		|=> cnt[6] == 32'($past(cnt[6]) + 32'h1))
		else $error("no carrier send not counted");

	upper_read_a: assert property (
		@(posedge mclk) disable iff (!rst_b)
		ce && mgmt_rd && stat_sel && mgmt_reg == 5'h10
		|=> mgmt_rvalid && mgmt_rdata == $past(cnt[0][31:16]))
		else $error("upper half read wrong");

	thr_reset_a: assert property (
		@(posedge mclk)
		!rst_b |=> coll_threshold == 8'h0f)
		else $error("threshold reset value wrong");

endmodule

// ---- test/tcs_mac_model.sv ----
// transmit mac and phy pin model feeding the statistics block
`timescale 1ns/1ps
module tcs_mac_model
(
	// clock
	input wire logic mclk,
	// toward the statistics block
	output logic tx_en,
	output logic col_pin,
	output logic crs_pin,
	output logic pkt_done,
	output logic pkt_ok
);
	initial
	begin
		tx_en = 1'b0;
		col_pin = 1'b0;
		crs_pin = 1'b0;
		pkt_done = 1'b0;
		pkt_ok = 1'b0;
	end

	// one attempt; tx_en drops for one cycle so the next rise is seen
	task automatic attempt(input int len, input int col_at,
		input logic crs);
		for (int i = 0; i <= len; i++)
		begin
			@(posedge mclk);
			#1;
			tx_en = i < len;
			crs_pin = crs && i < len;
			col_pin = i >= col_at && i < col_at + 2;
		end
	endtask

	// collided attempts first, then a clean one, then the done pulse
	task automatic send(input int ncol, input logic ok, input logic late,
		input logic crs);
		for (int k = 0; k < ncol; k++)
			attempt(late ? 530 : 30, late ? 520 : 10, 1'b1);
		attempt(30, 99, crs);
		@(posedge mclk);
		#1;
		pkt_done = 1'b1;
		pkt_ok = ok;
		@(posedge mclk);
		#1;
		pkt_done = 1'b0;
		pkt_ok = 1'b0;
	endtask
endmodule

// ---- test/test_tcs_stats.sv ----
// self-checking bench for the transmit collision statistics block
`timescale 1ns/1ps
module test_tcs_stats;
	logic mclk, rst_b, ce, tx_enable, half_duplex;
	logic defer_evt, defer_ipg_only;
	logic mgmt_rd, mgmt_wr, mgmt_rvalid, retry_late;
	logic tx_en, col_pin, crs_pin, pkt_done, pkt_ok;
	logic [4:0] mgmt_dev, mgmt_reg;
	logic [9:0] mgmt_page;
	logic [15:0] mgmt_wdata, mgmt_rdata, d;
	logic [7:0] coll_threshold;
	logic [31:0] exp_c [7] = '{default: 32'h0};
	int fails = 0;
	int n_checks = 0;
	// inc: one bit per counter that should step, total handled apart
	typedef struct packed {logic [4:0] ncol; logic ok, late, crs, hd, te;
		logic [7:0] thr; logic [6:0] inc;} tcs_row_t;
	tcs_row_t rows [8] = '{
		'{5'h01, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h0f, 7'h01},
		'{5'h03, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h0f, 7'h04},
		'{5'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h0f, 7'h40},
		'{5'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h0f, 7'h00},
		'{5'h01, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h0f, 7'h00},
		'{5'h01, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h0f, 7'h09},
		'{5'h10, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h0f, 7'h00},
		'{5'h10, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h10, 7'h02}};

	tcs_stats i_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce),
		.tx_enable(tx_enable), .half_duplex(half_duplex), .tx_en(tx_en),
		.pkt_done(pkt_done), .pkt_ok(pkt_ok), .defer_evt(defer_evt),
		.defer_ipg_only(defer_ipg_only), .crs_pin(crs_pin),
		.col_pin(col_pin), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
		.mgmt_dev(mgmt_dev), .mgmt_page(mgmt_page), .mgmt_reg(mgmt_reg),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .coll_threshold(coll_threshold),
		.retry_late(retry_late));
	tcs_mac_model i_mac (.mclk(mclk), .tx_en(tx_en), .col_pin(col_pin),
		.crs_pin(crs_pin), .pkt_done(pkt_done), .pkt_ok(pkt_ok));

	task automatic check(input logic [31:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// an edge passes after each read so strobes never overlap
	task automatic rd(input logic [9:0] page, input logic [4:0] rg,
		output logic [15:0] q);
		mgmt_rd = 1'b1;
		mgmt_dev = tcs_pkg::STAT_DEV;
		mgmt_page = page;
		mgmt_reg = rg;
		@(posedge mclk);
		#1;
		mgmt_rd = 1'b0;
		check(32'(mgmt_rvalid), 32'h1, "rvalid");
		q = mgmt_rdata;
		@(posedge mclk);
		#1;
	endtask

	task automatic wr_thr(input logic [7:0] thr);
		mgmt_wr = 1'b1;
		mgmt_dev = tcs_pkg::STAT_DEV;
		mgmt_page = tcs_pkg::CTRL_PAGE;
		mgmt_reg = tcs_pkg::THR_REG;
		mgmt_wdata = {7'h00, thr, thr[0]};
		@(posedge mclk);
		#1;
		mgmt_wr = 1'b0;
		@(posedge mclk);
		#1;
		check(32'(coll_threshold), 32'(thr), "threshold");
		check(32'(retry_late), 32'(thr[0]), "retry late");
	endtask

	task automatic check_all();
		logic [15:0] hi, lo;
		for (int c = 0; c < 7; c++)
		begin
			rd(tcs_pkg::STAT_PAGE, tcs_pkg::CNT_REG[c], hi);
			rd(tcs_pkg::STAT_PAGE, tcs_pkg::CNT_REG[c] + 5'h01, lo);
			check({hi, lo}, exp_c[c], "count");
		end
	endtask

	task automatic defer(input logic te, hd, ipg, cen);
		tx_enable = te;
		half_duplex = hd;
		defer_ipg_only = ipg;
		ce = cen;
		defer_evt = 1'b1;
		@(posedge mclk);
		#1;
		defer_evt = 1'b0;
		ce = 1'b1;
		@(posedge mclk);
		#1;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		#200us;
		fails++;
		end_of_test();
	end

	initial
	begin
		{rst_b, defer_evt, defer_ipg_only, mgmt_rd, mgmt_wr} = 5'h00;
		{ce, tx_enable, half_duplex} = 3'h7;
		{mgmt_dev, mgmt_page, mgmt_reg, mgmt_wdata} = 36'h0;
		repeat (8) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		check_all();
		rd(tcs_pkg::CTRL_PAGE, tcs_pkg::THR_REG, d);
		check(32'(d), 32'h1e, "threshold reg");
		rd(tcs_pkg::STAT_PAGE, 5'h16, d);
		check(32'(d), 32'h0, "unmapped");
		foreach (rows[r])
		begin
			tx_enable = rows[r].te;
			half_duplex = rows[r].hd;
			wr_thr(rows[r].thr);
			i_mac.send(rows[r].ncol, rows[r].ok, rows[r].late,
				rows[r].crs);
			for (int c = 0; c < 7; c++)
				exp_c[c] = exp_c[c] + 32'(rows[r].inc[c]);
			if (rows[r].hd && rows[r].te)
				exp_c[4] = exp_c[4] + 32'(rows[r].ncol);
			check_all();
		end
		defer(1'b1, 1'b0, 1'b0, 1'b1);
		defer(1'b1, 1'b1, 1'b1, 1'b1);
		defer(1'b0, 1'b1, 1'b0, 1'b1);
		defer(1'b1, 1'b1, 1'b0, 1'b0);
		exp_c[5] = exp_c[5] + 32'h1;
		check_all();
		// low half stays frozen between the two reads of a pair
		rd(tcs_pkg::STAT_PAGE, tcs_pkg::REG_DEFER, d);
		defer(1'b1, 1'b0, 1'b0, 1'b1);
		rd(tcs_pkg::STAT_PAGE, tcs_pkg::REG_DEFER + 5'h01, d);
		check(32'(d), exp_c[5], "pair snapshot");
		exp_c[5] = exp_c[5] + 32'h1;
		check_all();
		// mid-run reset clears all even with the enable low
		rst_b = 1'b0;
		ce = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		ce = 1'b1;
		exp_c = '{default: 32'h0};
		check(32'(coll_threshold), 32'h0f, "threshold reset");
		check(32'(retry_late), 32'h0, "retry late reset");
		check_all();
		end_of_test();
	end
endmodule
